/* File: verilog/adcc_pkg.sv */
// Package for the conversion control block: offsets, fields, states.
// Assumes a 32-bit APB bus on pclk and a converter core on the same clock.
package adcc_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h00; // Channel, mode, flag
    localparam logic [7:0] OFS_CMP_TRIG = 8'h04; // Compare, trigger, active
    localparam logic [7:0] OFS_RES_HIGH = 8'h08; // Result bits 9:8
    localparam logic [7:0] OFS_RES_LOW = 8'h0C; // Result bits 7:0
    localparam logic [7:0] OFS_CMP_VALUE = 8'h10; // 10-bit compare level
    localparam logic [7:0] OFS_CONFIG = 8'h14; // Conversion mode
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h18; // Sticky events, write 1
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1C; // Event mask
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_COMPLETE = 7; // Complete flag in first register
    localparam int BIT_IRQ_EN = 6; // Complete interrupt enable
    localparam int BIT_CONT = 5; // Continuous enable
    localparam int BIT_ACTIVE = 7; // Active flag in second register
    localparam int BIT_TRIG = 6; // Trigger select
    localparam int BIT_CMP_EN = 5; // Compare enable
    localparam int BIT_CMP_POL = 4; // Compare polarity
    localparam int BIT_MODE_LO = 2; // Mode field low bit in config
    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [4:0] CH_OFF = 5'h1F; // Converter off, input isolated
    localparam logic [4:0] CH_LAST_INPUT = 5'h1B; // Input 27
    localparam logic [4:0] CH_RESERVED = 5'h1C; // Reserved code
    localparam logic [4:0] CH_REF_HIGH = 5'h1D; // High reference
    localparam logic [4:0] CH_REF_LOW = 5'h1E; // Low reference
    localparam logic [1:0] MODE_8BIT = 2'h0; // 8-bit conversion
    localparam logic [1:0] MODE_10BIT = 2'h2; // 10-bit conversion
    localparam logic [4:0] RST_CHANNEL = 5'h1F; // Off after reset
    localparam logic [1:0] RST_MODE = 2'h0; // 8-bit after reset
    localparam logic [9:0] RST_CMP_VALUE = 10'h000; // Compare level reset
    localparam logic [7:0] RST_BYTE = 8'h00; // Generic byte reset
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b01, // Low power, waiting for a trigger
        ADCC_CONV = 2'b10 // Converter running
    } adcc_state_e;
    // Channel decode result
    typedef struct packed {
        logic is_input; // One of inputs 0 to 27
        logic is_ref_high; // High reference
        logic is_ref_low; // Low reference
        logic is_reserved; // Reserved code
        logic is_off; // Converter off
    } adcc_chan_s;
    // Request to the analog converter core
    typedef struct packed {
        logic power; // Converter powered up
        logic start; // One-cycle start pulse
        logic abort; // One-cycle abort pulse
        logic [4:0] channel; // Selected channel code
        logic [1:0] mode; // Conversion mode code
    } adcc_core_req_s;
    // Answer from the analog converter core
    typedef struct packed {
        logic done; // One-cycle completion pulse
        logic [9:0] data; // Raw 10-bit result
    } adcc_core_rsp_s;
endpackage

/* File: verilog/adcc_top.sv */
// Conversion control and status logic with an APB register slave.
// Assumes the converter core and the trigger source run on pclk.
//
// Overview of operation
// - Control write aborts, restarts with software trigger select unless channel off
// - Compare off: flag set every completion
// - Compare on: flag set only if true
// - Control write or low read clears flag
// - Flag set with enable raises interrupt while the mask bit is set
// - Continuous bit: one or repeated conversions
// - Five-bit channel code decoded
// - All-ones channel powers off, no extra
// - Single mode idles low power after completion
// - Active flag tracks conversion in progress
// - Trigger select: software write or hardware
// - Compare enable bit turns compare on
// - Polarity: below, or greater or equal
// - Hardware trigger starts on hw_trigger_in while idle
// - Results update unless compare fails
// - Mode code 00 8-bit, 10 10-bit
//
// The APB register port and the placing of the registers are this design's own decisions.
module adcc_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hw_trigger_in,
    input wire adcc_pkg::adcc_core_rsp_s core_rsp,
    output adcc_pkg::adcc_core_req_s core_req,
    output logic conv_irq
);
    import adcc_pkg::*;

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    // Classify a channel code
    function automatic adcc_chan_s decode_channel(input logic [4:0] code);
        adcc_chan_s d;
        d = '0;
        d.is_input = (code <= CH_LAST_INPUT);
        d.is_reserved = (code == CH_RESERVED);
        d.is_ref_high = (code == CH_REF_HIGH);
        d.is_ref_low = (code == CH_REF_LOW);
        d.is_off = (code == CH_OFF);
        return d;
    endfunction

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [4:0] channel_select; // Channel field
    logic continuous_enable; // Repeat after trigger
    logic complete_irq_enable; // Complete interrupt enable
    logic conv_complete_flag; // Read-only complete flag
    logic trigger_select; // 0 software, 1 hardware
    logic compare_enable; // Compare function on
    logic compare_polarity; // 0 below, 1 at or above
    logic [9:0] compare_value; // Compare level
    logic [1:0] conv_mode; // Mode field
    logic [1:0] result_high_bits; // Result bits 9:8
    logic [7:0] result_low_byte; // Result bits 7:0
    logic irq_status; // Sticky complete event
    logic irq_mask; // Event mask
    adcc_state_e state; // Sequencer state
    logic [4:0] next_channel_select;
    logic next_continuous_enable;
    logic next_complete_irq_enable;
    logic next_conv_complete_flag;
    logic next_trigger_select;
    logic next_compare_enable;
    logic next_compare_polarity;
    logic [9:0] next_compare_value;
    logic [1:0] next_conv_mode;
    logic [1:0] next_result_high_bits;
    logic [7:0] next_result_low_byte;
    logic next_irq_status;
    logic next_irq_mask;
    adcc_state_e next_state;
    logic [31:0] next_prdata;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic access; // Access phase of a transfer
    logic wr; // Write taking effect now
    logic rd; // Read taking effect now
    logic mapped; // Address hits a register
    logic wr_ctrl; // Write to the first control register
    logic [9:0] scaled; // Result in the selected width
    logic [9:0] cmp_level; // Compare level in that width
    logic cmp_true; // Compare condition
    logic accept; // Completion that updates results
    logic start_now; // Start a conversion this cycle

    assign access = psel & penable;
    assign wr = access & pwrite;
    assign rd = access & ~pwrite;
    assign mapped = (paddr[31:5] == '0) && (paddr[1:0] == 2'h0);
    assign wr_ctrl = wr && mapped && (paddr[7:0] == OFS_CTRL_STATUS);
    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // ------------------------------------------------------------
    // Compare and result scaling
    // ------------------------------------------------------------
    // 8-bit mode keeps the top eight bits right-justified
    always_comb
    begin
        if (conv_mode == MODE_10BIT)
        begin
            scaled = core_rsp.data;
            cmp_level = compare_value;
        end
        else
        begin
            scaled = {2'h0, core_rsp.data[9:2]};
            cmp_level = {2'h0, compare_value[7:0]};
        end
    end

    // Condition checked on the finished result first
    assign cmp_true = compare_polarity ? (scaled >= cmp_level)
                                       : (scaled < cmp_level);
    // Accept unless compare is on and false
    assign accept = (state == ADCC_CONV) && core_rsp.done
                    && (!compare_enable || cmp_true);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Decide whether a conversion begins this cycle
    always_comb
    begin
        adcc_chan_s ch;
        ch = decode_channel(wr_ctrl ? pwdata[4:0] : channel_select);
        start_now = 1'b0;
        if (ch.is_off)
        begin
            start_now = 1'b0;
        end
        else if (wr_ctrl)
        begin
            // Software trigger starts on the write itself
            start_now = !trigger_select;
        end
        else if (state == ADCC_IDLE)
        begin
            start_now = trigger_select && hw_trigger_in;
        end
        else if (core_rsp.done)
        begin
            start_now = continuous_enable;
        end
    end

    // State follows start, completion and abort
    always_comb
    begin
        next_state = state;
        unique case (state)
            ADCC_IDLE:
            begin
                if (start_now)
                    next_state = ADCC_CONV;
            end
            ADCC_CONV:
            begin
                if (start_now)
                    next_state = ADCC_CONV;
                else if (wr_ctrl || core_rsp.done)
                    next_state = ADCC_IDLE;
            end
        endcase
    end

    // Requests to the converter core
    always_comb
    begin
        core_req = '0;
        core_req.power = (state == ADCC_CONV);
        core_req.start = start_now;
        core_req.abort = wr_ctrl && (state == ADCC_CONV);
        core_req.channel = wr_ctrl ? pwdata[4:0] : channel_select;
        core_req.mode = conv_mode;
    end

    // ------------------------------------------------------------
    // Register updates
    // ------------------------------------------------------------
    // Next values of all software-visible state except the sequencer state
    always_comb
    begin
        next_channel_select = channel_select;
        next_continuous_enable = continuous_enable;
        next_complete_irq_enable = complete_irq_enable;
        next_conv_complete_flag = conv_complete_flag;
        next_trigger_select = trigger_select;
        next_compare_enable = compare_enable;
        next_compare_polarity = compare_polarity;
        next_compare_value = compare_value;
        next_conv_mode = conv_mode;
        next_result_high_bits = result_high_bits;
        next_result_low_byte = result_low_byte;
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        if (wr && mapped)
        begin
            unique case (paddr[7:0])
                OFS_CTRL_STATUS:
                begin
                    next_channel_select = pwdata[4:0];
                    next_continuous_enable = pwdata[BIT_CONT];
                    next_complete_irq_enable = pwdata[BIT_IRQ_EN];
                end
                OFS_CMP_TRIG:
                begin
                    // Bits 3:0 ignored; software keeps them zero
                    next_trigger_select = pwdata[BIT_TRIG];
                    next_compare_enable = pwdata[BIT_CMP_EN];
                    next_compare_polarity = pwdata[BIT_CMP_POL];
                end
                OFS_CMP_VALUE:
                    next_compare_value = pwdata[9:0];
                OFS_CONFIG:
                    next_conv_mode = pwdata[BIT_MODE_LO +: 2];
                OFS_IRQ_STATUS:
                    next_irq_status = irq_status & ~pwdata[0];
                OFS_IRQ_MASK:
                    next_irq_mask = pwdata[0];
                default:
                    next_irq_mask = irq_mask; // Result registers read-only
            endcase
        end
        // Clear on control write or low result read
        if (wr_ctrl || (rd && mapped && paddr[7:0] == OFS_RES_LOW))
            next_conv_complete_flag = 1'b0;
        // A completion in the same cycle wins over the clear
        if (accept)
        begin
            next_conv_complete_flag = 1'b1;
            next_result_high_bits = scaled[9:8];
            next_result_low_byte = scaled[7:0];
            // Event only counts while interrupts are enabled
            if (complete_irq_enable || (wr_ctrl && pwdata[BIT_IRQ_EN]))
                next_irq_status = 1'b1;
        end
    end

    // Read data captured in the setup phase
    always_comb
    begin
        next_prdata = '0;
        if (psel && !penable && !pwrite && mapped)
        begin
            unique case (paddr[7:0])
                OFS_CTRL_STATUS:
                    next_prdata[7:0] = {conv_complete_flag, complete_irq_enable,
                                        continuous_enable, channel_select};
                OFS_CMP_TRIG:
                    next_prdata[7:0] = {(state == ADCC_CONV), trigger_select,
                                        compare_enable, compare_polarity,
                                        4'h0};
                OFS_RES_HIGH:
                    next_prdata[1:0] = result_high_bits;
                OFS_RES_LOW:
                    next_prdata[7:0] = result_low_byte;
                OFS_CMP_VALUE:
                    next_prdata[9:0] = compare_value;
                OFS_CONFIG:
                    next_prdata[BIT_MODE_LO +: 2] = conv_mode;
                OFS_IRQ_STATUS:
                    next_prdata[0] = irq_status;
                OFS_IRQ_MASK:
                    next_prdata[0] = irq_mask;
                default:
                    next_prdata = '0;
            endcase
        end
        else if (access)
        begin
            next_prdata = prdata; // Hold through the access phase
        end
    end

    // ------------------------------------------------------------
    // Flip-flops
    // ------------------------------------------------------------
    // Register every next value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ADCC_IDLE;
            channel_select <= RST_CHANNEL;
            continuous_enable <= 1'b0;
            complete_irq_enable <= 1'b0;
            conv_complete_flag <= 1'b0;
            trigger_select <= 1'b0;
            compare_enable <= 1'b0;
            compare_polarity <= 1'b0;
            compare_value <= RST_CMP_VALUE;
            conv_mode <= RST_MODE;
            result_high_bits <= 2'h0;
            result_low_byte <= RST_BYTE;
            irq_status <= 1'b0;
            irq_mask <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            state <= next_state;
            channel_select <= next_channel_select;
            continuous_enable <= next_continuous_enable;
            complete_irq_enable <= next_complete_irq_enable;
            conv_complete_flag <= next_conv_complete_flag;
            trigger_select <= next_trigger_select;
            compare_enable <= next_compare_enable;
            compare_polarity <= next_compare_polarity;
            compare_value <= next_compare_value;
            conv_mode <= next_conv_mode;
            result_high_bits <= next_result_high_bits;
            result_low_byte <= next_result_low_byte;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            prdata <= next_prdata;
        end
    end

    // Level interrupt while an unmasked event is pending
    assign conv_irq = irq_status & irq_mask;
endmodule

/* File: testbench/adcc_top_asserts.sv */
// Checker for the conversion control block, bound to its top module.
// Assumes zero-wait APB on pclk and a converter core pulsing done once.
module adcc_top_asserts
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hw_trigger_in,
    input wire adcc_pkg::adcc_core_rsp_s core_rsp,
    input wire adcc_pkg::adcc_core_req_s core_req,
    input wire logic conv_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import adcc_pkg::*;
    // ------------------------------------------------------------
    // Shadow of written control bits
    // ------------------------------------------------------------
    logic acc; // Accepted write access
    logic wr_ctrl; // Write to the first control register
    logic wr_trig; // Write to the second control register
    logic cont_q, next_cont, trig_q, next_trig;
    logic [4:0] chan_q, next_chan;
    assign acc = psel && penable && pwrite && pready;
    assign wr_ctrl = acc && paddr == 32'h0;
    assign wr_trig = acc && paddr == 32'h4;
    // Next shadow values
    always_comb
    begin
        next_cont = wr_ctrl ? pwdata[5] : cont_q;
        next_chan = wr_ctrl ? pwdata[4:0] : chan_q;
        next_trig = wr_trig ? pwdata[6] : trig_q;
    end
    // Shadow registers, reset like the design
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cont_q <= 1'b0;
            chan_q <= 5'h1F;
            trig_q <= 1'b0;
        end
        else
        begin
            cont_q <= next_cont;
            chan_q <= next_chan;
            trig_q <= next_trig;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Start pulse then powered converter
    sequence s_launch;
        core_req.start ##1 core_req.power;
    endsequence
    sequence s_hw_go;
        hw_trigger_in && trig_q && !core_req.power && chan_q != 5'h1F && !wr_ctrl;
    endsequence
    a_sw_start: assert property (wr_ctrl && !trig_q && pwdata[4:0] != 5'h1F |-> s_launch)
        else $error("control write did not start a conversion");
    a_busy_abort: assert property (wr_ctrl && core_req.power |-> core_req.abort)
        else $error("control write did not abort the running conversion");
    a_off_quiet: assert property (wr_ctrl && pwdata[4:0] == 5'h1F |->
        !core_req.start ##1 !core_req.power [*3])
        else $error("off code started or kept the converter");
    a_single_idle: assert property (core_rsp.done && core_req.power && !cont_q && !wr_ctrl
        |=> !core_req.power)
        else $error("single conversion did not return to low power");
    a_cont_again: assert property (core_rsp.done && core_req.power && cont_q && !wr_ctrl
        |-> s_launch ##0 $stable(core_req.channel))
        else $error("continuous mode did not restart at once");
    a_hw_start: assert property (s_hw_go |-> s_launch)
        else $error("hardware trigger did not start a conversion");
    a_hw_ignored: assert property (hw_trigger_in && !trig_q && !core_req.power
        && !wr_ctrl |-> !core_req.start)
        else $error("hardware trigger started with software select");
    a_hw_waits: assert property (wr_ctrl && trig_q |-> !core_req.start)
        else $error("control write started with hardware select");
    a_irq_clear: assert property (acc && paddr == 32'h18 && pwdata[0] && !core_rsp.done
        |=> !conv_irq)
        else $error("interrupt stayed after clear");
    a_irq_cause: assert property ($rose(conv_irq) |->
        $past(core_rsp.done) || $past(acc && paddr == 32'h1C))
        else $error("interrupt rose without a completion");
endmodule

bind adcc_top adcc_top_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hw_trigger_in(hw_trigger_in),
    .core_rsp(core_rsp), .core_req(core_req), .conv_irq(conv_irq));

/* File: testbench/testbench.sv */
// Self-checking bench for the conversion control block.
// Assumes the bench stands in for the converter core and trigger source.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import adcc_pkg::*;
    // ------------------------------------------------------------
    // Signals and bookkeeping
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, hw_trigger_in, pready, pslverr, conv_irq;
    logic [31:0] paddr, pwdata, prdata, d;
    adcc_core_rsp_s core_rsp;
    adcc_core_req_s core_req;
    logic [32:0] note_q[$]; // Expected error flag and read data
    logic [32:0] note;
    logic [9:0] res, cd; // Last accepted result, next raw data
    logic [4:0] chans [5] = '{5'h00, 5'h03, 5'h1B, 5'h1D, 5'h1E};
    logic pol, hit;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #20 pclk = ~pclk;
    adcc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_trigger_in(hw_trigger_in), .core_rsp(core_rsp),
        .core_req(core_req), .conv_irq(conv_irq));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, noting the expected answer first
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        input logic [32:0] exp);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= wd;
        note_q.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, 33'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, {1'b0, exp});
    endtask
    // Converter core: wait for power, answer after a random delay
    task automatic convert(input logic [9:0] v);
        int n;
        n = 0;
        while (core_req.power !== 1'b1 && n < 20)
        begin
            @(negedge pclk);
            n++;
        end
        repeat (1 + $urandom % 4) @(posedge pclk);
        core_rsp <= '{done: 1'b1, data: v};
        @(posedge pclk);
        core_rsp <= '{done: 1'b0, data: ~v};
        @(negedge pclk);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Monitor: oldest note against each answered transfer
    // ------------------------------------------------------------
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && note_q.size() > 0)
        begin
            note = note_q.pop_front();
            chk({31'h0, pslverr}, {31'h0, note[32]});
            if (!pwrite)
                chk(prdata, note[31:0]);
        end
    end
    // Hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, hw_trigger_in} = 5'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        core_rsp = '{done: 1'b0, data: 10'h0};
        d = $urandom(29);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h1F);
        rd(8'h04, 32'h00);
        apb(1'b0, 8'h20, 32'h0, 33'h100000000);
        // Software start on inputs and both references, 8-bit results
        foreach (chans[i])
        begin
            wr(8'h00, {27'h0, chans[i]});
            @(negedge pclk);
            chk({27'h0, core_req.channel}, {27'h0, chans[i]});
            rd(8'h04, 32'h80);
            d = $urandom;
            convert(d[9:0]);
            chk({31'h0, core_req.power}, 32'h0);
            rd(8'h00, {24'h0, 3'h4, chans[i]});
            rd(8'h04, 32'h00);
            rd(8'h0C, {24'h0, d[9:2]});
            rd(8'h00, {27'h0, chans[i]});
        end
        // Interrupt raised, cleared, masked, disabled
        wr(8'h1C, 32'h1);
        wr(8'h00, 32'h47);
        convert(10'h155);
        chk({31'h0, conv_irq}, 32'h1);
        rd(8'h18, 32'h1);
        wr(8'h18, 32'h1);
        @(negedge pclk);
        chk({31'h0, conv_irq}, 32'h0);
        wr(8'h1C, 32'h0);
        wr(8'h00, 32'h47);
        convert(10'h2AA);
        chk({31'h0, conv_irq}, 32'h0);
        rd(8'h18, 32'h1);
        wr(8'h18, 32'h1);
        wr(8'h00, 32'h07);
        convert(10'h0F0);
        rd(8'h18, 32'h0);
        // Abort mid-conversion with a new channel
        wr(8'h00, 32'h05);
        wr(8'h00, 32'h06);
        @(negedge pclk);
        chk({27'h0, core_req.channel}, 32'h06);
        convert(10'h3C4);
        rd(8'h00, 32'h86);
        // Continuous run, then stopped with the off code
        wr(8'h00, 32'h22);
        convert(10'h111);
        convert(10'h2EC);
        rd(8'h0C, 32'hBB);
        wr(8'h00, 32'h3F);
        repeat (3) @(negedge pclk);
        chk({31'h0, core_req.power}, 32'h0);
        // Hardware trigger
        wr(8'h04, 32'h40);
        wr(8'h00, 32'h02);
        repeat (3) @(negedge pclk);
        chk({31'h0, core_req.power}, 32'h0);
        @(posedge pclk);
        hw_trigger_in <= 1'b1;
        @(posedge pclk);
        hw_trigger_in <= 1'b0;
        @(negedge pclk);
        chk({31'h0, core_req.power}, 32'h1);
        rd(8'h04, 32'hC0);
        convert(10'h0AB);
        rd(8'h00, 32'h82);
        // Compare at the boundary, both polarities, 10-bit mode
        wr(8'h14, 32'h8);
        @(negedge pclk);
        chk({30'h0, core_req.mode}, {30'h0, MODE_10BIT});
        wr(8'h10, 32'h200);
        for (int i = 0; i < 4; i++)
        begin
            pol = i[1];
            cd = i[0] ? 10'h200 : 10'h1FF;
            hit = pol ? cd >= 10'h200 : cd < 10'h200;
            wr(8'h04, {26'h0, 1'b1, pol, 4'h0});
            wr(8'h00, 32'h01);
            convert(cd);
            if (hit)
                res = cd;
            rd(8'h00, {24'h0, hit, 7'h01});
            rd(8'h08, {30'h0, res[9:8]});
            rd(8'h0C, {24'h0, res[7:0]});
        end
        // Hardware pulse with software select must not start
        @(posedge pclk);
        hw_trigger_in <= 1'b1;
        @(posedge pclk);
        hw_trigger_in <= 1'b0;
        @(negedge pclk);
        chk({31'h0, core_req.power}, 32'h0);
        repeat (4) @(posedge pclk);
        tally_and_finish();
    end
endmodule
